/* File: shared/flash_pin_defs.svh */
/*
  timing counts and field layout for the serial flash pin front end.
  assumes a 100 mhz system clock; included by bare name.
*/
`ifndef FLASH_PIN_DEFS_SVH
`define FLASH_PIN_DEFS_SVH
`define BYTE_W            4'h8
`define BIT_CNT_W         3
`define SYNC_STAGES       3
`define CLK_PERIOD_NS     10
`define PWRUP_DELAY_NS    100000
`define PWRUP_DELAY_CYC   ((`PWRUP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: shared/flash_pin_pkg.sv */
/*
  types shared by the serial flash pin front end.
  assumes nothing of its surroundings.
*/
package flash_pin_pkg;
  // filtered pin levels travel together
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic din;
    logic pause_n;
    logic wprot_n;
  } pins_t;

  // command framing phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_BODY
  } phase_t;
endpackage : flash_pin_pkg

/* File: design/pin_sync.sv */
/*
  three-stage synchroniser for one asynchronous pin.
  assumes the pin may change at any time relative to mclk_in.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1   // level shown during reset
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] stage_reg;   // stage 0 is read only by stage 1

  // shift chain
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      stage_reg <= {3{RESET_LEVEL}};
    else
      stage_reg <= {stage_reg[1:0], pin_in};
  end

  // a change counts only once stages 1 and 2 agree
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      level_out <= RESET_LEVEL;
    else if (stage_reg[1] == stage_reg[2])
      level_out <= stage_reg[2];
  end
endmodule : pin_sync

/* File: design/flash_pin_front.sv */
/*
  pin front end of a serial flash: samples the spi pins, frames commands,
  shifts bytes in and out, handles pause, write protect and supply lockout.
  assumes an external spi host in mode 0 or 3 and an array core behind.
*/
// How it works
// - sample data on rising clock, msb first
// - change output after falling clock, msb first
// - only modes 0 and 3 are served
// - select falling starts a new command
// - select rising completes or aborts command
// - output high impedance while deselected
// - pause freezes shifting, output high impedance
// - write protect pin blocks protected writes
// - low supply inhibits all array writes
`timescale 1ns/1ns
`include "flash_pin_defs.svh"
module flash_pin_front #(
  parameter int PWRUP_CYC = `PWRUP_DELAY_CYC   // power-up select delay, cycles
) (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  // spi pins
  input  wire logic       sel_n_in,
  input  wire logic       sclk_in,
  input  wire logic       din_in,
  input  wire logic       pause_n_in,
  input  wire logic       wprot_n_in,
  output logic            dout_out,
  output logic            dout_oe_out,
  // supply monitor
  input  wire logic       supply_lockout_level_in,
  // core side
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out,
  output logic            rx_opcode_out,
  output logic            cmd_start_out,
  output logic            cmd_end_out,
  output logic            cmd_abort_out,
  input  wire logic [7:0] tx_byte_in,
  output logic            tx_load_out,
  input  wire logic       write_req_in,
  input  wire logic       write_prot_in,
  output logic            write_grant_out,
  output logic            ready_out
);
  initial
  begin
    if (PWRUP_CYC < 1)
      $error("PWRUP_CYC must be at least one");
  end

  flash_pin_pkg::pins_t   pin_lvl;        // filtered pin levels
  flash_pin_pkg::pins_t   pin_prev_reg;   // previous filtered levels
  flash_pin_pkg::phase_t  phase_reg;      // framing phase
  logic [2:0]             bit_cnt_reg;    // bits received in this byte
  logic [7:0]             shin_reg;       // input shift register
  logic [7:0]             shout_reg;      // output shift register
  logic [31:0]            pwr_cnt_reg;    // power-up delay counter
  logic                   paused_reg;     // pause in force
  logic                   rise, fall, sel_fall, sel_rise, active;

  // one synchroniser per pin
  pin_sync #(.RESET_LEVEL(1'b1)) u_sel (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .pin_in(sel_n_in), .level_out(pin_lvl.sel_n));
  pin_sync #(.RESET_LEVEL(1'b0)) u_clk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .pin_in(sclk_in), .level_out(pin_lvl.sclk));
  pin_sync #(.RESET_LEVEL(1'b0)) u_din (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .pin_in(din_in), .level_out(pin_lvl.din));
  pin_sync #(.RESET_LEVEL(1'b1)) u_hld (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .pin_in(pause_n_in), .level_out(pin_lvl.pause_n));
  pin_sync #(.RESET_LEVEL(1'b1)) u_wp (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .pin_in(wprot_n_in), .level_out(pin_lvl.wprot_n));

  // edge history
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      pin_prev_reg <= '{sel_n: 1'b1, sclk: 1'b0, din: 1'b0, pause_n: 1'b1, wprot_n: 1'b1};
    else
      pin_prev_reg <= pin_lvl;
  end

  assign sel_fall = pin_prev_reg.sel_n & ~pin_lvl.sel_n;
  assign sel_rise = ~pin_prev_reg.sel_n & pin_lvl.sel_n;
  // edges only count while selected and not paused
  assign active   = ~pin_lvl.sel_n & ~paused_reg & ready_out;
  assign rise     = active & ~pin_prev_reg.sclk & pin_lvl.sclk;
  assign fall     = active & pin_prev_reg.sclk & ~pin_lvl.sclk;

  // power-up delay; selects before it are ignored
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      pwr_cnt_reg <= 32'h0;
    else if (pwr_cnt_reg < 32'(PWRUP_CYC))
      pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
  end
  assign ready_out = (pwr_cnt_reg >= 32'(PWRUP_CYC));

  // pause only while selected; taken at any clock level
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      paused_reg <= 1'b0;
    else if (pin_lvl.sel_n)
      paused_reg <= 1'b0;
    else
      paused_reg <= ~pin_lvl.pause_n;
  end

  // command framing
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      phase_reg <= flash_pin_pkg::PH_IDLE;
    else if (pin_lvl.sel_n || !ready_out)
      phase_reg <= flash_pin_pkg::PH_IDLE;
    else
    begin
      case (phase_reg)
        flash_pin_pkg::PH_IDLE:
          if (sel_fall)
            phase_reg <= flash_pin_pkg::PH_OPCODE;
        flash_pin_pkg::PH_OPCODE:
          if (rise && bit_cnt_reg == 3'h7)
            phase_reg <= flash_pin_pkg::PH_BODY;
        flash_pin_pkg::PH_BODY:
          phase_reg <= flash_pin_pkg::PH_BODY;
        default:
          phase_reg <= flash_pin_pkg::PH_IDLE;
      endcase
    end
  end

  // input shifting on rising edges, msb first
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      bit_cnt_reg <= 3'h0;
      shin_reg    <= 8'h00;
    end
    else if (pin_lvl.sel_n)
      bit_cnt_reg <= 3'h0;
    else if (rise && phase_reg != flash_pin_pkg::PH_IDLE)
    begin
      shin_reg    <= {shin_reg[6:0], pin_lvl.din};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // byte delivery to the core
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      rx_byte_out   <= 8'h00;
      rx_valid_out  <= 1'b0;
      rx_opcode_out <= 1'b0;
    end
    else
    begin
      rx_valid_out <= 1'b0;
      if (rise && phase_reg != flash_pin_pkg::PH_IDLE && bit_cnt_reg == 3'h7)
      begin
        rx_byte_out   <= {shin_reg[6:0], pin_lvl.din};
        rx_valid_out  <= 1'b1;
        rx_opcode_out <= (phase_reg == flash_pin_pkg::PH_OPCODE);
      end
    end
  end

  // framing strobes; a select rise mid-byte is an abort
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cmd_start_out <= 1'b0;
      cmd_end_out   <= 1'b0;
      cmd_abort_out <= 1'b0;
    end
    else
    begin
      cmd_start_out <= sel_fall && ready_out && phase_reg == flash_pin_pkg::PH_IDLE;
      cmd_end_out   <= sel_rise && phase_reg == flash_pin_pkg::PH_BODY
                       && bit_cnt_reg == 3'h0;
      cmd_abort_out <= sel_rise && phase_reg != flash_pin_pkg::PH_IDLE
                       && !(phase_reg == flash_pin_pkg::PH_BODY && bit_cnt_reg == 3'h0);
    end
  end

  // output shifting on falling edges; new byte at byte boundary
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      shout_reg   <= 8'h00;
      dout_out    <= 1'b0;
      tx_load_out <= 1'b0;
    end
    else
    begin
      tx_load_out <= 1'b0;
      if (fall && phase_reg == flash_pin_pkg::PH_BODY)
      begin
        if (bit_cnt_reg == 3'h0)
        begin
          dout_out    <= tx_byte_in[7];
          shout_reg   <= {tx_byte_in[6:0], 1'b0};
          tx_load_out <= 1'b1;
        end
        else
        begin
          dout_out  <= shout_reg[7];
          shout_reg <= {shout_reg[6:0], 1'b0};
        end
      end
    end
  end

  // drive only while selected and not paused
  assign dout_oe_out = ~pin_lvl.sel_n & ~paused_reg & ready_out;

  // write gating: protect pin and supply lockout
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      write_grant_out <= 1'b0;
    else
      write_grant_out <= write_req_in
                         && !(write_prot_in && !pin_lvl.wprot_n)
                         && !supply_lockout_level_in
                         && ready_out;
  end

  // bit counter frozen during pause
  a_pause_freeze: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    paused_reg && !pin_lvl.sel_n |=> $stable(bit_cnt_reg))
    else $error("bit count moved during pause");
  a_deselect_hiz: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_lvl.sel_n |-> !dout_oe_out)
    else $error("output driven while deselected");
  a_rise_sample: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rise && phase_reg != flash_pin_pkg::PH_IDLE |=> shin_reg[0] == $past(pin_lvl.din))
    else $error("data not sampled on rise");
  a_dout_fall: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !$past(fall) |-> $stable(dout_out))
    else $error("output changed without falling edge");
  a_deselect_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_lvl.sel_n |=> bit_cnt_reg == 3'h0 && phase_reg == flash_pin_pkg::PH_IDLE)
    else $error("counter not cleared on deselect");
  a_start_strobe: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sel_fall && ready_out && phase_reg == flash_pin_pkg::PH_IDLE |=> cmd_start_out)
    else $error("no start on select fall");
  a_lockout_block: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    supply_lockout_level_in |=> !write_grant_out)
    else $error("write granted at low supply");
  a_wprot_block: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    write_prot_in && !pin_lvl.wprot_n |=> !write_grant_out)
    else $error("protected write granted");
  a_end_or_abort: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sel_rise && phase_reg != flash_pin_pkg::PH_IDLE |=> cmd_end_out ^ cmd_abort_out)
    else $error("select rise neither ended nor aborted");
endmodule : flash_pin_front

/* File: verification/spi_host_model.sv */
/*
  spi host model: drives select, clock, data and pause pins of the flash.
  assumes the device takes data at clock rise; serves mode 0 and mode 3.
*/
`timescale 1ns/1ns
module spi_host_model (
  // pins to the device
  output logic      sel_n_out,
  output logic      sclk_out,
  output logic      din_out,
  output logic      pause_n_out,
  // pins from the device
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  logic mode3;  // clock idles high when set

  // idle pins at time zero
  initial
  begin
    mode3 = 1'b0;
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out = 1'b0;
    pause_n_out = 1'b1;
  end

  // pick clock mode while deselected; clock parks at its idle level
  task automatic set_mode(input logic m);
    mode3 = m;
    sclk_out = m;
    #100;
  endtask : set_mode

  // select edge with settle time on both sides
  task automatic sel(input logic lvl);
    #40 sel_n_out = lvl;
    if (lvl)
      din_out = ~din_out;  // released data line shows no stale bit
    #60;
  endtask : sel

  // pause pin; caller keeps select low around it
  task automatic hold(input logic lvl);
    #40 pause_n_out = lvl;
    #60;
  endtask : hold

  // n bits msb first, 125 ns per bit; device bit taken at rise
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    // start 2 ns past a 10 ns boundary: with 125 ns bits every pin change
    // then misses both system clock edges
    while ($time % 10 != 2)
      #1;
    for (int i = 0; i < n; i++)
    begin
      sclk_out = 1'b0;
      din_out = tx[7 - i];
      #62 sclk_out = 1'b1;
      rx = {rx[6:0], dout_oe_in ? dout_in : 1'bx};
      #63;
    end
    sclk_out = mode3;
  endtask : bits
endmodule : spi_host_model

/* File: verification/tb_top.sv */
/*
  self-checking bench for the flash pin front end.
  assumes the host model beside it and a short power-up count.
*/
`timescale 1ns/1ns
module tb_top;
  logic       mclk_in, rst_n_in, sel_n, sclk, din, pause_n, wprot_n, dout, dout_oe;
  logic       lock, rx_valid, rx_opcode, cmd_start, cmd_end, cmd_abort, tx_load;
  logic       wreq, wprot, grant, ready;
  logic [7:0] rx_byte, tx_byte;
  int         failures, num_checks, cycles, n_start, n_end, n_abort, n_load;
  logic [8:0] rxq[$];  // received bytes with opcode flag on top

  flash_pin_front #(.PWRUP_CYC(20)) flash_pin_front_i (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .sel_n_in(sel_n), .sclk_in(sclk), .din_in(din),
    .pause_n_in(pause_n), .wprot_n_in(wprot_n), .dout_out(dout), .dout_oe_out(dout_oe),
    .supply_lockout_level_in(lock), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_opcode_out(rx_opcode), .cmd_start_out(cmd_start), .cmd_end_out(cmd_end),
    .cmd_abort_out(cmd_abort), .tx_byte_in(tx_byte), .tx_load_out(tx_load),
    .write_req_in(wreq), .write_prot_in(wprot), .write_grant_out(grant),
    .ready_out(ready));
  spi_host_model host_i (.sel_n_out(sel_n), .sclk_out(sclk), .din_out(din),
    .pause_n_out(pause_n), .dout_in(dout), .dout_oe_in(dout_oe));

  // free-running system clock
  initial mclk_in = 1'b0;
  always #5 mclk_in = ~mclk_in;

  // pulse counters, byte capture and hang guard
  always @(posedge mclk_in)
  begin
    cycles++;
    if (rx_valid === 1'b1)
      rxq.push_back({rx_opcode, rx_byte});
    n_start += (cmd_start === 1'b1);
    n_end += (cmd_end === 1'b1);
    n_abort += (cmd_abort === 1'b1);
    n_load += (tx_load === 1'b1);
    if (cycles > 20000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  // oldest captured byte against expectation; empty queue reads as all ones
  task automatic check_rx(input logic [8:0] exp);
    logic [8:0] got;
    got = 9'h1ff;
    if (rxq.size() > 0)
      got = rxq.pop_front();
    check_word(got, exp);
  endtask : check_rx

  task automatic t_powerup;
    repeat (10) @(negedge mclk_in);
    check_bit(ready, 1'b0);
    for (int i = 0; i < 40 && ready !== 1'b1; i++)
      @(negedge mclk_in);
    check_bit(ready, 1'b1);
    check_bit(dout_oe, 1'b0);
    $display("test powerup done");
  endtask : t_powerup

  // opcode, one data byte in, one byte read back
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input logic [7:0] tx);
    int         s;
    int         en;
    int         ld;   // load pulses seen before the data byte
    logic [7:0] got;
    s = n_start;
    en = n_end;
    rxq.delete();
    @(negedge mclk_in) tx_byte = tx;
    host_i.sel(1'b0);
    host_i.bits(op, 8, got);
    ld = n_load;
    host_i.bits(dat, 8, got);
    check_word({1'b0, got}, {1'b0, tx});
    check_word(9'(n_load - ld), 9'h001);
    host_i.sel(1'b1);
    check_bit(dout_oe, 1'b0);
    check_word(9'(n_start - s), 9'h001);
    check_word(9'(n_end - en), 9'h001);
    check_rx({1'b1, op});
    check_rx({1'b0, dat});
    $display("test transfer %h done", op);
  endtask : xfer

  // partial byte aborts; next select starts a fresh opcode
  task automatic t_abort;
    int         a;
    logic [7:0] got;
    a = n_abort;
    host_i.sel(1'b0);
    host_i.bits(8'hff, 5, got);
    host_i.sel(1'b1);
    check_word(9'(n_abort - a), 9'h001);
    rxq.delete();
    host_i.sel(1'b0);
    host_i.bits(8'h81, 8, got);
    host_i.sel(1'b1);
    check_rx({1'b1, 8'h81});
    $display("test abort done");
  endtask : t_abort

  // clock edges during pause are ignored and the shift state is kept
  task automatic t_pause;
    logic [7:0] got;
    rxq.delete();
    host_i.sel(1'b0);
    host_i.bits(8'h5a, 8, got);
    host_i.bits(8'hc3, 4, got);
    check_bit(dout_oe, 1'b1);
    host_i.hold(1'b0);
    check_bit(dout_oe, 1'b0);
    host_i.bits(8'hff, 3, got);
    host_i.hold(1'b1);
    host_i.bits(8'h30, 4, got);
    host_i.sel(1'b1);
    check_rx({1'b1, 8'h5a});
    check_rx({1'b0, 8'hc3});
    $display("test pause done");
  endtask : t_pause

  // every mix of request, protect, pin and lockout
  task automatic t_write;
    logic [3:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = 4'(i);
      @(negedge mclk_in) {wreq, wprot, wprot_n, lock} = v;
      repeat (8) @(negedge mclk_in);
      check_bit(grant, v[3] & ~(v[2] & ~v[1]) & ~v[0]);
    end
    $display("test write gate done");
  endtask : t_write

  task test_done;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // main sequence
  initial
  begin
    rst_n_in = 1'b0;   // held for eight cycles
    wprot_n  = 1'b0;   // protect pin low until the write test
    lock     = 1'b1;   // supply low until the write test
    wreq     = 1'b0;
    wprot    = 1'b0;
    tx_byte  = 8'h00;
    repeat (8) @(negedge mclk_in);
    rst_n_in = 1'b1;
    t_powerup();
    xfer(8'ha5, 8'h3c, 8'h96);
    host_i.set_mode(1'b1);
    xfer(8'h5a, 8'hf0, 8'h69);
    host_i.set_mode(1'b0);
    t_abort();
    t_pause();
    t_write();
    test_done();
  end
endmodule : tb_top
